//--- hw/sep_pkg.sv
/*
  Shared constants, command codes and frame layout for the serial EEPROM
  program-control link. Assumes a 50 MHz system clock on both ends.
*/
package sep_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int LCLK_PERIOD_NS  = 160;
  localparam int LCLK_HALF_CYCLES = LCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // least chip-select low and settle time, rounded up
  localparam int CS_GAP_NS     = 160;
  localparam int GAP_CYCLES    =
    (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // programming time is not known; plain default
  localparam int PROG_TIME_NS  = 5000000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;

  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 16;
  localparam int OP_W       = 2;
  localparam int HDR_BITS   = OP_W + ADDR_W;
  localparam int FRAME_BITS = 1 + HDR_BITS + DATA_W;
  localparam int SHORT_BITS = 1 + HDR_BITS;
  localparam int READ_BITS  = 1 + DATA_W;
  localparam int WORDS      = 256;
  localparam int FIFO_DEPTH = 32;

  localparam logic [4:0] HDR_LAST  = 5'h09;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_WDIS = 2'h0;
  localparam logic [1:0] SUB_BULK = 2'h1;
  localparam logic [1:0] SUB_EALL = 2'h2;
  localparam logic [1:0] SUB_WEN  = 2'h3;

  typedef enum logic [2:0] {
    CMD_READ          = 3'h0,
    CMD_WRITE_EN      = 3'h1,
    CMD_WRITE         = 3'h2,
    BULK_WRITE_CMD    = 3'h3,
    WRITE_DISABLE_CMD = 3'h4,
    CMD_ERASE         = 3'h5,
    ERASE_ALL_CMD     = 3'h6,
    CMD_NONE          = 3'h7
  } sep_cmd_t;

  function automatic sep_cmd_t sep_decode(input logic [HDR_BITS-1:0] h);
    logic [1:0] op;
    logic [1:0] sub;
    op  = h[HDR_BITS-1 -: OP_W];
    sub = h[ADDR_W-1 -: 2];
    case (op)
      OP_READ:  sep_decode = CMD_READ;
      OP_WRITE: sep_decode = CMD_WRITE;
      OP_ERASE: sep_decode = CMD_ERASE;
      default: begin
        case (sub)
          SUB_WEN:  sep_decode = CMD_WRITE_EN;
          SUB_BULK: sep_decode = BULK_WRITE_CMD;
          SUB_EALL: sep_decode = ERASE_ALL_CMD;
          default:  sep_decode = WRITE_DISABLE_CMD;
        endcase
      end
    endcase
  endfunction

  function automatic logic sep_is_prog(input sep_cmd_t c);
    sep_is_prog = (c == CMD_WRITE) || (c == BULK_WRITE_CMD) ||
                  (c == CMD_ERASE) || (c == ERASE_ALL_CMD);
  endfunction
endpackage

//--- hw/sep_if.sv
/*
  Four-wire serial link between host and EEPROM device.
  The data output is tri-state; data_line resolves it with a pull-up.
*/
`timescale 1ns/1ps
interface sep_if;
  logic chip_select;
  logic serial_clock_in;
  logic serial_data_in;
  logic data_out;
  logic data_out_oe;
  logic data_line;

  // undriven line floats high through the pull-up
  assign data_line = data_out_oe ? data_out : 1'b1;

  modport dev (
    input  chip_select,
    input  serial_clock_in,
    input  serial_data_in,
    output data_out,
    output data_out_oe
  );
  modport host (
    output chip_select,
    output serial_clock_in,
    output serial_data_in,
    input  data_line
  );
endinterface

//--- hw/sep_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides, registered flags.
  Assumes DEPTH is a power of two.
*/
`timescale 1ns/1ps
module sep_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  logic             clk_i,
  input  logic             reset_n_i,
  // fill side
  input  logic             in_valid_i,
  output logic             in_ready_o,
  input  logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic             out_valid_o,
  input  logic             out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_ready_i && out_valid_o;
  assign next_count = count + CW'(push) - CW'(pop);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count       <= next_count;
      in_ready_o  <= next_count != CW'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end
endmodule

//--- hw/sep_device.sv
/*
  EEPROM device end: 256 x 16 array, serial command decode, write
  enable latch, self-timed programming and ready/busy on the data output.
  Assumes the link pins are asynchronous to clk_i and that the serial
  clock is at least four system clocks per phase.
*/
// What this block does
// RULE1 - start bit, opcode, address, optional data
// RULE2 - decode opcode 00 by two address MSBs
// RULE3 - sample and launch on clock rising
// RULE4 - power up write-disabled, need enable first
// RULE5 - bulk write fills all words when enabled
// RULE6 - chip-select fall after data starts programming
// RULE7 - write-disable takes effect at chip-select fall
// RULE8 - reads work whatever the enable state
// RULE9 - word erase sets addressed word to ones
// RULE10 - erase-all sets every word to ones
// RULE11 - chip-select fall after address starts erase
// RULE12 - busy while programming, ignore new instructions
// RULE13 - host waits for ready before new commands
// RULE14 - selected after programming: low busy, high ready
// RULE15 - output tri-stated while chip select low
// RULE16 - toggling chip select never disturbs programming
// RULE17 - start bit clears ready, may begin frame
// RULE18 - chip select low resets interface logic
// RULE19 - writes need no prior erase
// RULE20 - host disables writes after programming
// RULE21 - programming while disabled is ignored entirely
// RULE22 - programming time is a parameter
`timescale 1ns/1ps
module sep_device
  import sep_pkg::*;
#(
  // RULE22 programming time parameter
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  // clock and reset
  input  logic clk_i,
  input  logic reset_n_i,
  // serial link
  sep_if.dev   link,
  // status
  output logic write_enabled_o,
  output logic busy_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HDR  = 3'h1,
    ST_DATA = 3'h2,
    ST_READ = 3'h3,
    ST_DONE = 3'h4,
    ST_SKIP = 3'h5
  } sep_state_t;

  logic [2:0]           sync1;
  logic [2:0]           sync2;
  logic                 lclk_d;
  logic                 cs_d;
  logic                 cs_s;
  logic                 din_s;
  logic                 lclk_rise;
  logic                 cs_fall;
  sep_state_t           state;
  logic [4:0]           cnt;
  logic [HDR_BITS-1:0]  hdr;
  logic [HDR_BITS-1:0]  next_hdr;
  logic [DATA_W-1:0]    wdata;
  logic [READ_BITS-1:0] out_sr;
  sep_cmd_t             cmd;
  sep_cmd_t             next_cmd;
  logic [DATA_W-1:0]    mem [WORDS];
  logic [ADDR_W-1:0]    addr;
  logic                 status_mode;
  logic                 status_clear;
  logic                 frame_end;
  logic                 prog_go;
  logic [31:0]          timer;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      lclk_d <= 1'b0;
      cs_d   <= 1'b0;
    end else begin
      sync1 <= {link.chip_select, link.serial_clock_in,
                link.serial_data_in};
      sync2 <= sync1;
      lclk_d <= sync2[1];
      cs_d   <= sync2[2];
    end
  end

  assign cs_s     = sync2[2];
  assign din_s    = sync2[0];
  // RULE3 rising edge sampling
  assign lclk_rise = sync2[1] && !lclk_d && cs_s;
  assign cs_fall  = !cs_s && cs_d;
  assign next_hdr = {hdr[HDR_BITS-2:0], din_s};
  // RULE2 opcode decode
  assign next_cmd = sep_decode(next_hdr);
  assign addr     = hdr[ADDR_W-1:0];
  assign frame_end = cs_fall && (state == ST_DONE) && !busy_o;
  // RULE21 disabled programming ignored
  assign prog_go  = frame_end && write_enabled_o && sep_is_prog(cmd);
  // RULE17 start bit clears ready
  assign status_clear = lclk_rise && din_s && !busy_o &&
                        (state == ST_IDLE) && status_mode;

  // frame receiver
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state  <= ST_IDLE;
      cnt    <= 5'h00;
      hdr    <= '0;
      wdata  <= '0;
      out_sr <= '0;
      cmd    <= CMD_NONE;
    end else if (!cs_s) begin
      // RULE18 deselect resets interface
      state <= ST_IDLE;
      cnt   <= 5'h00;
    end else if (lclk_rise && !busy_o) begin
      // RULE12 no instruction while busy
      case (state)
        ST_IDLE: begin
          // RULE1 leading zeros skipped
          if (din_s) begin
            state <= ST_HDR;
            cnt   <= 5'h00;
          end
        end
        ST_HDR: begin
          hdr <= next_hdr;
          cnt <= cnt + 5'h01;
          if (cnt == HDR_LAST) begin
            cmd <= next_cmd;
            cnt <= 5'h00;
            case (next_cmd)
              CMD_READ: begin
                // RULE8 read ignores enable
                state  <= ST_READ;
                out_sr <= {1'b0, mem[next_hdr[ADDR_W-1:0]]};
              end
              CMD_WRITE, BULK_WRITE_CMD: begin
                state <= ST_DATA;
              end
              default: begin
                state <= ST_DONE;
              end
            endcase
          end
        end
        ST_DATA: begin
          // RULE1 data msb first
          wdata <= {wdata[DATA_W-2:0], din_s};
          cnt   <= cnt + 5'h01;
          if (cnt == DATA_LAST) begin
            state <= ST_DONE;
          end
        end
        ST_READ: begin
          out_sr <= {out_sr[READ_BITS-2:0], 1'b0};
        end
        ST_DONE: begin
          // extra clock before deselect voids the command
          state <= ST_SKIP;
        end
        ST_SKIP: begin
          state <= ST_SKIP;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // write enable latch
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // RULE4 power up disabled
      write_enabled_o <= 1'b0;
    end else if (frame_end) begin
      if (cmd == CMD_WRITE_EN) begin
        write_enabled_o <= 1'b1;
      end else if (cmd == WRITE_DISABLE_CMD) begin
        // RULE7 disable at deselect
        write_enabled_o <= 1'b0;
      end
    end
  end

  // self-timed programming; only the timer ends it, not chip select
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
      timer  <= 32'h0000_0000;
    end else if (prog_go) begin
      // RULE6 RULE11 start on deselect
      busy_o <= 1'b1;
      timer  <= 32'(PROG_CYCLES - 1);
    end else if (busy_o) begin
      // RULE16 cycle runs to completion
      if (timer == 32'h0000_0000) begin
        busy_o <= 1'b0;
      end else begin
        timer <= timer - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_mode <= 1'b0;
    end else if (prog_go) begin
      status_mode <= 1'b1;
    end else if (status_clear) begin
      status_mode <= 1'b0;
    end
  end

  // array has no reset; contents are undefined until programmed
  always_ff @(posedge clk_i) begin
    if (prog_go) begin
      case (cmd)
        CMD_WRITE: begin
          // RULE19 direct overwrite
          mem[addr] <= wdata;
        end
        BULK_WRITE_CMD: begin
          // RULE5 all words at once
          for (int i = 0; i < WORDS; i++) begin
            mem[i] <= wdata;
          end
        end
        CMD_ERASE: begin
          // RULE9 word to ones
          mem[addr] <= ERASED_WORD;
        end
        ERASE_ALL_CMD: begin
          // RULE10 array to ones
          for (int i = 0; i < WORDS; i++) begin
            mem[i] <= ERASED_WORD;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // output pin, three clocks behind the pins
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link.data_out    <= 1'b0;
      link.data_out_oe <= 1'b0;
    end else if (!cs_s) begin
      // RULE15 tri-state when deselected
      link.data_out    <= 1'b0;
      link.data_out_oe <= 1'b0;
    end else if (status_mode) begin
      // RULE14 busy low, ready high
      link.data_out    <= !busy_o;
      link.data_out_oe <= 1'b1;
    end else begin
      // RULE3 read bits launched after rising edge
      link.data_out    <= out_sr[READ_BITS-1];
      link.data_out_oe <= state == ST_READ;
    end
  end
endmodule

//--- hw/sep_host.sv
/*
  Host end: queues user commands in a FIFO, drives the serial link,
  collects read data and polls ready/busy after programming.
  Assumes a device on sep_if and a pull-up on the data line.
*/
`timescale 1ns/1ps
module sep_host
  import sep_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  logic              clk_i,
  input  logic              reset_n_i,
  // command queue
  input  logic              cmd_valid_i,
  output logic              cmd_ready_o,
  input  sep_cmd_t          cmd_op_i,
  input  logic [ADDR_W-1:0] cmd_addr_i,
  input  logic [DATA_W-1:0] cmd_data_i,
  // read result and status
  output logic              rd_valid_o,
  output logic [DATA_W-1:0] rd_data_o,
  output logic              busy_o,
  // serial link
  sep_if.host               link
);
  localparam int QW = 3 + ADDR_W + DATA_W;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_SHIFT = 3'h1,
    H_READ  = 3'h2,
    H_GAP   = 3'h3,
    H_POLL  = 3'h4
  } sep_hstate_t;

  sep_hstate_t           hstate;
  logic                  q_valid;
  logic                  q_pop;
  logic [QW-1:0]         q_data;
  sep_cmd_t              q_cmd;
  logic [ADDR_W-1:0]     q_addr;
  logic [HDR_BITS-1:0]   q_hdr;
  sep_cmd_t              cur_cmd;
  logic [FRAME_BITS-1:0] sr;
  logic [4:0]            bits;
  logic [7:0]            phase;
  logic                  wrap;
  logic [7:0]            wait_cnt;
  logic                  poll_pending;
  logic [DATA_W-1:0]     rsr;
  logic                  line1;
  logic                  line_s;

  // drains the queue only while the link is idle; the user stalls only when the FIFO is full
  assign q_pop = (hstate == H_IDLE) && q_valid;

  sep_fifo #(
    .WIDTH (QW),
    .DEPTH (DEPTH)
  ) sep_fifo_i (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (cmd_valid_i),
    .in_ready_o  (cmd_ready_o),
    .in_data_i   ({cmd_op_i, cmd_addr_i, cmd_data_i}),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop),
    .out_data_o  (q_data)
  );

  assign q_cmd  = sep_cmd_t'(q_data[QW-1 -: 3]);
  assign q_addr = q_data[DATA_W +: ADDR_W];
  assign wrap   = phase == 8'(LCLK_HALF_CYCLES - 1);

  // RULE2 header for each command
  always_comb begin
    case (q_cmd)
      CMD_READ:          q_hdr = {OP_READ, q_addr};
      CMD_WRITE:         q_hdr = {OP_WRITE, q_addr};
      CMD_ERASE:         q_hdr = {OP_ERASE, q_addr};
      CMD_WRITE_EN:      q_hdr = {OP_EXT, SUB_WEN, 6'h00};
      BULK_WRITE_CMD:    q_hdr = {OP_EXT, SUB_BULK, 6'h00};
      ERASE_ALL_CMD:     q_hdr = {OP_EXT, SUB_EALL, 6'h00};
      default:           q_hdr = {OP_EXT, SUB_WDIS, 6'h00};
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      line1  <= 1'b1;
      line_s <= 1'b1;
    end else begin
      line1  <= link.data_line;
      line_s <= line1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase <= 8'h00;
    end else if ((hstate == H_SHIFT || hstate == H_READ) && !wrap) begin
      phase <= phase + 8'h01;
    end else begin
      phase <= 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hstate               <= H_IDLE;
      link.chip_select     <= 1'b0;
      link.serial_clock_in <= 1'b0;
      link.serial_data_in  <= 1'b0;
      cur_cmd              <= CMD_NONE;
      sr                   <= '0;
      bits                 <= 5'h00;
      wait_cnt             <= 8'h00;
      poll_pending         <= 1'b0;
      rsr                  <= '0;
      rd_data_o            <= '0;
      rd_valid_o           <= 1'b0;
      busy_o               <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      case (hstate)
        H_IDLE: begin
          busy_o <= 1'b0;
          if (q_valid) begin
            // RULE1 start bit, header, data
            cur_cmd              <= q_cmd;
            sr                   <= {1'b1, q_hdr, q_data[DATA_W-1:0]};
            bits                 <= sep_is_prog(q_cmd) &&
                                    (q_cmd == CMD_WRITE ||
                                     q_cmd == BULK_WRITE_CMD) ?
                                    5'(FRAME_BITS) : 5'(SHORT_BITS);
            link.chip_select     <= 1'b1;
            link.serial_data_in  <= 1'b1;
            link.serial_clock_in <= 1'b0;
            busy_o               <= 1'b1;
            hstate               <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (wrap && !link.serial_clock_in) begin
            // RULE3 data steady at rising edge
            link.serial_clock_in <= 1'b1;
            bits                 <= bits - 5'h01;
          end else if (wrap) begin
            link.serial_clock_in <= 1'b0;
            if (bits == 5'h00) begin
              if (cur_cmd == CMD_READ) begin
                bits   <= 5'(READ_BITS);
                hstate <= H_READ;
              end else begin
                // RULE6 RULE11 deselect before next edge
                link.chip_select <= 1'b0;
                poll_pending     <= sep_is_prog(cur_cmd);
                wait_cnt         <= 8'h00;
                hstate           <= H_GAP;
              end
            end else begin
              sr                  <= {sr[FRAME_BITS-2:0], 1'b0};
              link.serial_data_in <= sr[FRAME_BITS-2];
            end
          end
        end
        H_READ: begin
          if (wrap && !link.serial_clock_in) begin
            // sample late in the low phase, after sync delay
            rsr  <= {rsr[DATA_W-2:0], line_s};
            bits <= bits - 5'h01;
            if (bits == 5'h01) begin
              rd_data_o        <= {rsr[DATA_W-2:0], line_s};
              rd_valid_o       <= 1'b1;
              link.chip_select <= 1'b0;
              poll_pending     <= 1'b0;
              wait_cnt         <= 8'h00;
              hstate           <= H_GAP;
            end else begin
              link.serial_clock_in <= 1'b1;
            end
          end else if (wrap) begin
            link.serial_clock_in <= 1'b0;
          end
        end
        H_GAP: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (wait_cnt == 8'(GAP_CYCLES - 1)) begin
            wait_cnt <= 8'h00;
            if (poll_pending) begin
              link.chip_select <= 1'b1;
              hstate           <= H_POLL;
            end else begin
              hstate <= H_IDLE;
            end
          end
        end
        H_POLL: begin
          // RULE13 hold off until ready
          if (wait_cnt != 8'(GAP_CYCLES - 1)) begin
            wait_cnt <= wait_cnt + 8'h01;
          end else if (line_s) begin
            link.chip_select <= 1'b0;
            poll_pending     <= 1'b0;
            wait_cnt         <= 8'h00;
            hstate           <= H_GAP;
          end
        end
        default: begin
          hstate <= H_IDLE;
        end
      endcase
    end
  end
endmodule

//--- tb/sep_link_chk.sv
/*
  Checker for the serial EEPROM link: watches the shared wires and the
  device status. Assumes the device syncs link pins with two flops.
*/
`timescale 1ns/1ps
module sep_link_chk #(
  parameter int PROG_CYCLES = 60
) (
  // clock and reset
  input logic clk_i,
  input logic reset_n_i,
  // link wires
  input logic chip_select,
  input logic serial_clock_in,
  input logic data_out,
  input logic data_out_oe,
  // device status
  input logic busy_o,
  input logic write_enabled_o
);
  int busy_cnt;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_cnt <= 0;
    end else if (busy_o) begin
      busy_cnt <= busy_cnt + 1;
    end else begin
      busy_cnt <= 0;
    end
  end

  a_oe_released: assert property (
    (!chip_select)[*4] |-> !data_out_oe)
    else $error("data output driven while deselected");
  a_busy_shown_low: assert property (
    chip_select[*5] ##0 busy_o |-> data_out_oe && !data_out)
    else $error("busy not shown as low");
  a_ready_shown_high: assert property (
    $fell(busy_o) && chip_select |-> ##[0:4] (data_out_oe && data_out))
    else $error("ready not shown as high");
  a_busy_length: assert property (
    $fell(busy_o) |-> busy_cnt >= PROG_CYCLES && busy_cnt <= PROG_CYCLES + 1)
    else $error("programming time wrong");
  a_prog_at_fall: assert property (
    $rose(busy_o) |-> !chip_select)
    else $error("programming began while selected");
  a_wen_at_fall: assert property (
    $changed(write_enabled_o) |-> !chip_select)
    else $error("enable state changed while selected");
  a_prog_needs_wen: assert property (
    $rose(busy_o) |-> write_enabled_o)
    else $error("programming while disabled");
  a_clock_idle_low: assert property (
    !chip_select |-> !serial_clock_in)
    else $error("link clock moved while deselected");
  a_clock_phase: assert property (
    $rose(serial_clock_in) |-> serial_clock_in[*4] ##1 !serial_clock_in)
    else $error("link clock high phase wrong");
endmodule

//--- tb/serial_eeprom_program_control_test.sv
/*
  Bench joining host and device ends over the link; drives the host
  command queue and checks read-back data. Assumes 50 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %0s exp %h got %h", nm, e, g); end end
module serial_eeprom_program_control_test;
  import sep_pkg::*;
  localparam int PROG = 60;
  logic              clk_i;
  logic              reset_n_i;
  logic              cmd_valid_i;
  logic              cmd_ready;
  sep_cmd_t          cmd_op_i;
  logic [ADDR_W-1:0] cmd_addr_i;
  logic [DATA_W-1:0] cmd_data_i;
  logic              rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic              h_busy;
  logic              d_busy;
  logic              wen;
  int                n_errors;
  int                n_compared;
  int                n_prog;
  int                n_full;
  logic [DATA_W-1:0] rd_q[$];
  logic [DATA_W-1:0] exp_rd;

  sep_if sep_if_i();
  sep_device #(.PROG_CYCLES(PROG)) sep_device_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .link(sep_if_i),
    .write_enabled_o(wen), .busy_o(d_busy));
  sep_host sep_host_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .busy_o(h_busy), .link(sep_if_i));
  sep_link_chk #(.PROG_CYCLES(PROG)) sep_link_chk_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .chip_select(sep_if_i.chip_select),
    .serial_clock_in(sep_if_i.serial_clock_in),
    .data_out(sep_if_i.data_out), .data_out_oe(sep_if_i.data_out_oe),
    .busy_o(d_busy), .write_enabled_o(wen));

  always #10 clk_i = ~clk_i;
  always @(posedge d_busy) n_prog++;

  // read results come back in queue order
  always @(negedge clk_i) begin
    if (rd_valid === 1'b1) begin
      `CHK("read expected", 1'b1, rd_q.size() > 0)
      exp_rd = (rd_q.size() > 0) ? rd_q.pop_front() : 16'h0000;
      `CHK("read data", exp_rd, rd_data)
    end
  end

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // held until a rising edge sees ready high
  task automatic send(input sep_cmd_t op, input logic [7:0] a,
                      input logic [15:0] d);
    @(negedge clk_i);
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    while (cmd_ready !== 1'b1) begin
      n_full++;
      @(negedge clk_i);
    end
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    send(CMD_READ, a, 16'h0000);
  endtask

  // host idle can blip between queued commands, so ask for four
  task automatic idle();
    int k;
    k = 0;
    while (k < 4) begin
      @(negedge clk_i);
      k = (h_busy === 1'b0 && d_busy === 1'b0) ? k + 1 : 0;
    end
  endtask

  // about 50k clocks, several times the expected run length
  initial begin
    #1000000;
    n_errors++;
    $display("[FAIL] watchdog exp done got hang");
    finish_test();
  end

  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_op_i = CMD_NONE;
    cmd_addr_i = 8'h00;
    cmd_data_i = 16'h0000;
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK("enable at reset", 1'b0, wen)
    send(BULK_WRITE_CMD, 8'h00, 16'h0000);
    idle();
    `CHK("prog count", 0, n_prog)
    send(CMD_WRITE_EN, 8'hC0, 16'h0000);
    idle();
    `CHK("enable set", 1'b1, wen)
    send(BULK_WRITE_CMD, 8'h40, 16'hA5C3);
    rd(8'h00, 16'hA5C3);
    rd(8'h80, 16'hA5C3);
    rd(8'hFE, 16'hA5C3);
    send(CMD_WRITE, 8'h10, 16'h1234);
    send(CMD_WRITE, 8'h12, 16'h0F0F);
    rd(8'h10, 16'h1234);
    rd(8'h12, 16'h0F0F);
    send(CMD_ERASE, 8'h10, 16'h0000);
    rd(8'h10, 16'hFFFF);
    rd(8'h14, 16'hA5C3);
    idle();
    `CHK("prog count", 4, n_prog)
    send(WRITE_DISABLE_CMD, 8'h00, 16'h0000);
    idle();
    `CHK("enable cleared", 1'b0, wen)
    send(ERASE_ALL_CMD, 8'h80, 16'h0000);
    send(CMD_WRITE, 8'h12, 16'h0000);
    rd(8'h12, 16'h0F0F);
    idle();
    `CHK("prog count", 4, n_prog)
    send(CMD_WRITE_EN, 8'hC0, 16'h0000);
    send(ERASE_ALL_CMD, 8'h80, 16'h0000);
    rd(8'h40, 16'hFFFF);
    rd(8'h12, 16'hFFFF);
    repeat (40) send(CMD_WRITE_EN, 8'hC0, 16'h0000);
    send(WRITE_DISABLE_CMD, 8'h00, 16'h0000);
    idle();
    `CHK("queue refused", 1'b1, n_full > 0)
    `CHK("prog count", 5, n_prog)
    `CHK("enable final", 1'b0, wen)
    `CHK("reads left", 0, rd_q.size())
    finish_test();
  end
endmodule
